//--- hw/avmf_block.sv
/*
 * Alert-mask and output-voltage format command registers of a power
 * bus target, with the walk that re-scales dependent voltage words
 * when the format changes.
 * Assumes a protocol layer outside delivers one decoded transaction
 * per cmd.valid pulse and that the dependent word store answers a
 * read in the same cycle as dep_rd.
 */
// Functional notes
// - The misc mask sits behind command 1Bh with selector 7Fh, the vendor mask behind 1Bh with selector 80h.
// - A mask is written by a word write carrying selector and mask byte.
// - A mask is read by a process call that returns the selected one-byte mask.
// - A mask bit of 0 lets its condition drive the alert line and 1 blocks it, for misc bit 0 and vendor bits 7, 6, 3, 2 and 1 only.
// - The misc mask reads 01h fixed, so its only source never alerts.
// - Clearing the self-check mask bit can let a power-up glitch raise the alert.
// - Clearing the sync mask bit can let a stack enable briefly raise the alert.
// - The format register is command 20h, written by byte write, read by byte read.
// - The format register takes writes only while conversion is off.
// - Format byte is relative flag at 7, mode at 6:5 and exponent at 4:0.
// - The relative flag selects absolute format at 0 and relative at 1.
// - The mode field is fixed at 00b linear, any other value is invalid.
// - The exponent is two's complement and only -12 through -4 is accepted.
// - A format change re-scales every dependent voltage word to the new format.
// - Stored voltage words keep the format they were written in until converted.
`timescale 1ns/1ps
`include "avmf_regs.svh"

module avmf_block (
	input  wire logic                 clk,           // 100 MHz clock
	input  wire logic                 resetn,        // Sync reset, low
	input  wire logic                 ce,            // Clock enable
	input  wire avmf_pkg::avmf_cmd_t  cmd,           // Decoded command
	output avmf_pkg::avmf_rsp_t       rsp,           // Command answer
	input  wire avmf_pkg::avmf_nvm_t  nvm,           // NVM reload
	input  wire logic                 conv_enabled,  // Converter running
	input  wire logic [7:0]           misc_status,   // Misc status
	input  wire logic [7:0]           vendor_status, // Vendor status
	input  wire logic                 alert_in,      // Alert wire level
	output logic                      alert_out,     // Alert drive level
	output logic                      alert_oe_n,    // Alert drive, low
	output logic [7:0]                vout_format,   // Format in force
	output logic                      conv_busy,     // Re-scale running
	output logic [1:0]                dep_addr,      // Dependent index
	output logic                      dep_rd,        // Dependent read
	input  wire logic [15:0]          dep_rdata,     // Dependent word
	output logic                      dep_wr,        // Dependent write
	output logic [15:0]               dep_wdata      // Re-scaled word
);

	avmf_pkg::avmf_top_state_t st_reg;
	avmf_pkg::avmf_top_state_t st_next;

	logic        is_mask_cmd;
	logic        is_fmt_cmd;
	logic        sel_misc;
	logic        sel_vendor;
	logic        mask_wr;
	logic        fmt_wr_ok;
	logic        fmt_differs;
	logic [7:0]  misc_mask;
	logic [7:0]  vendor_mask;
	logic        alert_req;
	logic [15:0] scaled;
	logic        line_seen;

	avmf_pkg::avmf_fmt_t wr_fmt;

	// ************************************************************
	// Command decode
	// ************************************************************
	assign is_mask_cmd = cmd.valid
		&& (cmd.code == `AVMF_CMD_ALERT_MASK);
	assign is_fmt_cmd  = cmd.valid
		&& (cmd.code == `AVMF_CMD_VOUT_FORMAT);
	assign sel_misc    = (cmd.sel == `AVMF_SEL_MISC);
	assign sel_vendor  = (cmd.sel == `AVMF_SEL_VENDOR);
	assign wr_fmt      = avmf_pkg::avmf_fmt_t'(cmd.data);

	assign mask_wr = ce && is_mask_cmd && sel_vendor
		&& (cmd.kind == avmf_pkg::AVMF_XFER_WRITE_WORD);

	// A write in the middle of a re-scale would leave words in mixed
	// formats, so it is refused until the walk is done.
	assign fmt_wr_ok = is_fmt_cmd
		&& (cmd.kind == avmf_pkg::AVMF_XFER_WRITE_BYTE)
		&& !conv_enabled
		&& !st_reg.busy
		&& (wr_fmt.mode == `AVMF_FMT_MODE_LINEAR)
		&& avmf_pkg::exp_supported(wr_fmt.param);

	assign fmt_differs = (wr_fmt.relative_format_flag != st_reg.fmt.relative_format_flag)
		|| (wr_fmt.param != st_reg.fmt.param);

	// The wire level is only observed; the drive follows the masks.
	assign line_seen = alert_in;

	// ************************************************************
	// Leaf modules
	// ************************************************************
	avmf_mask_bank u_bank (
		.clk           (clk),
		.resetn        (resetn),
		.ce            (ce),
		.wr_en         (mask_wr),
		.wr_mask       (cmd.data),
		.nvm_load      (nvm.load),
		.nvm_mask      (nvm.vendor_mask),
		.misc_status   (misc_status),
		.vendor_status (vendor_status),
		.misc_mask     (misc_mask),
		.vendor_mask   (vendor_mask),
		.alert_req     (alert_req)
	);

	avmf_scaler u_scaler (
		.value      (dep_rdata),
		.old_exp    (st_reg.old_fmt.param),
		.new_exp    (st_reg.fmt.param),
		.signed_fmt (st_reg.fmt.relative_format_flag),
		.result     (scaled)
	);

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb
	begin
		st_next = st_reg;

		// Answer defaults: one-cycle pulse, refused and zero
		st_next.rsp.valid = cmd.valid;
		st_next.rsp.ack   = 1'b0;
		st_next.rsp.data  = 8'h00;

		if (is_mask_cmd)
		begin
			case (cmd.kind)
				avmf_pkg::AVMF_XFER_WRITE_WORD:
				begin
					// Misc mask write is taken but changes nothing
					st_next.rsp.ack = sel_misc || sel_vendor;
				end
				avmf_pkg::AVMF_XFER_PROC_CALL:
				begin
					st_next.rsp.ack = sel_misc || sel_vendor;
					if (sel_misc)
						st_next.rsp.data = misc_mask;
					else if (sel_vendor)
						st_next.rsp.data = vendor_mask;
					else
						st_next.rsp.data = 8'h00;
				end
				default:
				begin
					st_next.rsp.ack = 1'b0;
				end
			endcase
		end
		else if (is_fmt_cmd)
		begin
			case (cmd.kind)
				avmf_pkg::AVMF_XFER_READ_BYTE:
				begin
					st_next.rsp.ack  = 1'b1;
					st_next.rsp.data = st_reg.fmt;
				end
				avmf_pkg::AVMF_XFER_WRITE_BYTE:
				begin
					st_next.rsp.ack = fmt_wr_ok;
				end
				default:
				begin
					st_next.rsp.ack = 1'b0;
				end
			endcase
		end

		// Format write; mode is forced to linear
		if (fmt_wr_ok)
		begin
			st_next.fmt.relative_format_flag   = wr_fmt.relative_format_flag;
			st_next.fmt.mode  = `AVMF_FMT_MODE_LINEAR;
			st_next.fmt.param = wr_fmt.param;
			if (fmt_differs)
			begin
				// Old format kept so stored words are converted from
				// the exponent they were written with
				st_next.old_fmt = st_reg.fmt;
				st_next.busy    = 1'b1;
				st_next.idx     = `AVMF_DEP_FIRST;
				st_next.dep_rd  = 1'b1;
				st_next.conv    = avmf_pkg::AVMF_CONV_READ;
			end
		end

		// Dependent word walk
		case (st_reg.conv)
			avmf_pkg::AVMF_CONV_IDLE:
			begin
				st_next.dep_wr = 1'b0;
			end
			avmf_pkg::AVMF_CONV_READ:
			begin
				st_next.dep_rd    = 1'b0;
				st_next.dep_wr    = 1'b1;
				st_next.dep_wdata = scaled;
				st_next.conv      = avmf_pkg::AVMF_CONV_WRITE;
			end
			avmf_pkg::AVMF_CONV_WRITE:
			begin
				st_next.dep_wr = 1'b0;
				if (st_reg.idx == `AVMF_DEP_LAST)
				begin
					st_next.busy = 1'b0;
					st_next.conv = avmf_pkg::AVMF_CONV_IDLE;
				end
				else
				begin
					st_next.idx    = st_reg.idx + 2'h1;
					st_next.dep_rd = 1'b1;
					st_next.conv   = avmf_pkg::AVMF_CONV_READ;
				end
			end
			default:
			begin
				st_next.dep_rd = 1'b0;
				st_next.dep_wr = 1'b0;
				st_next.busy   = 1'b0;
				st_next.conv   = avmf_pkg::AVMF_CONV_IDLE;
			end
		endcase

		// Reload restores the dependent words too, so any walk is moot
		if (nvm.load)
		begin
			st_next.fmt.relative_format_flag   = nvm.format[`AVMF_FMT_REL_BIT];
			st_next.fmt.mode  = `AVMF_FMT_MODE_LINEAR;
			st_next.fmt.param = avmf_pkg::exp_supported(
				nvm.format[`AVMF_FMT_PARAM_HI:`AVMF_FMT_PARAM_LO])
				? nvm.format[`AVMF_FMT_PARAM_HI:`AVMF_FMT_PARAM_LO]
				: st_reg.fmt.param;
			st_next.old_fmt = st_next.fmt;
			st_next.busy    = 1'b0;
			st_next.dep_rd  = 1'b0;
			st_next.dep_wr  = 1'b0;
			st_next.conv    = avmf_pkg::AVMF_CONV_IDLE;
		end

		// Open-drain alert: pull low only for an unmasked condition
		st_next.alert_oe_n  = !alert_req;
		st_next.alert_level = 1'b0;
	end

	// ************************************************************
	// State register
	// ************************************************************
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			st_reg             <= '0;
			st_reg.fmt         <= avmf_pkg::avmf_fmt_t'(`AVMF_FMT_RST);
			st_reg.old_fmt     <= avmf_pkg::avmf_fmt_t'(`AVMF_FMT_RST);
			st_reg.conv        <= avmf_pkg::AVMF_CONV_IDLE;
			st_reg.alert_oe_n  <= 1'b1;
			st_reg.alert_level <= 1'b0;
		end
		else if (ce)
			st_reg <= st_next;
	end

	// ************************************************************
	// Outputs, all straight from the state register
	// ************************************************************
	assign rsp         = st_reg.rsp;
	assign alert_out   = st_reg.alert_level;
	assign alert_oe_n  = st_reg.alert_oe_n;
	assign vout_format = st_reg.fmt;
	assign conv_busy   = st_reg.busy;
	assign dep_addr    = st_reg.idx;
	assign dep_rd      = st_reg.dep_rd;
	assign dep_wr      = st_reg.dep_wr;
	assign dep_wdata   = st_reg.dep_wdata;

endmodule

//--- inc/avmf_regs.svh
/*
 * Command codes, selectors, field positions, reset values and counts
 * of the alert-mask and output-voltage format command registers.
 * Assumes it is included by its bare name wherever a number is needed.
 */
`ifndef AVMF_REGS_SVH
`define AVMF_REGS_SVH

// ************************************************************
// Command codes and selector bytes
// ************************************************************
`define AVMF_CMD_ALERT_MASK   8'h1B
`define AVMF_CMD_VOUT_FORMAT  8'h20
`define AVMF_SEL_MISC         8'h7F
`define AVMF_SEL_VENDOR       8'h80

// ************************************************************
// Alert mask layout and reset values
// ************************************************************
`define AVMF_MISC_MASK_RST    8'h01
`define AVMF_MISC_SUPPORTED   8'h01
`define AVMF_VENDOR_MASK_RST  8'hCE
`define AVMF_VENDOR_WMASK     8'hCE
`define AVMF_VM_POWER_ON_BIT  7
`define AVMF_VM_SELF_BIT      6
`define AVMF_VM_RESET_BIT     3
`define AVMF_VM_BACK_BIT      2
`define AVMF_VM_SYNC_BIT      1

// ************************************************************
// Output-voltage format layout, reset value and exponent range
// ************************************************************
`define AVMF_FMT_REL_BIT      7
`define AVMF_FMT_MODE_HI      6
`define AVMF_FMT_MODE_LO      5
`define AVMF_FMT_PARAM_HI     4
`define AVMF_FMT_PARAM_LO     0
`define AVMF_FMT_MODE_LINEAR  2'h0
`define AVMF_FMT_RST          8'h14
`define AVMF_EXP_MIN          5'h14
`define AVMF_EXP_MAX          5'h1C

// ************************************************************
// Dependent output-voltage words walked on a format change
// ************************************************************
`define AVMF_DEP_FIRST        2'h0
`define AVMF_DEP_LAST         2'h3

`endif

//--- inc/avmf_pkg.sv
/*
 * Types shared by the format/mask block and its mask bank leaf module.
 * Assumes avmf_regs.svh is on the include path.
 */
`include "avmf_regs.svh"

package avmf_pkg;

	// ************************************************************
	// Transaction carriers
	// ************************************************************
	typedef enum logic [1:0] {
		AVMF_XFER_WRITE_BYTE = 2'b00,
		AVMF_XFER_WRITE_WORD = 2'b01,
		AVMF_XFER_READ_BYTE  = 2'b10,
		AVMF_XFER_PROC_CALL  = 2'b11
	} avmf_xfer_t;

	typedef struct packed {
		logic       valid;
		avmf_xfer_t kind;
		logic [7:0] code;
		logic [7:0] sel;
		logic [7:0] data;
	} avmf_cmd_t;

	typedef struct packed {
		logic       valid;
		logic       ack;
		logic [7:0] data;
	} avmf_rsp_t;

	typedef struct packed {
		logic       load;
		logic [7:0] vendor_mask;
		logic [7:0] format;
	} avmf_nvm_t;

	typedef struct packed {
		logic       relative_format_flag;
		logic [1:0] mode;
		logic [4:0] param;
	} avmf_fmt_t;

	// ************************************************************
	// State
	// ************************************************************
	typedef enum logic [1:0] {
		AVMF_CONV_IDLE  = 2'b00,
		AVMF_CONV_READ  = 2'b01,
		AVMF_CONV_WRITE = 2'b10
	} avmf_conv_t;

	typedef struct packed {
		logic [7:0] vendor_mask;
	} avmf_bank_state_t;

	typedef struct packed {
		avmf_fmt_t   fmt;
		avmf_fmt_t   old_fmt;
		avmf_conv_t  conv;
		logic [1:0]  idx;
		logic        dep_rd;
		logic        dep_wr;
		logic [15:0] dep_wdata;
		logic        busy;
		avmf_rsp_t   rsp;
		logic        alert_oe_n;
		logic        alert_level;
	} avmf_top_state_t;

	// Exponents -12..-4 are 5'h14..5'h1C, so an unsigned compare works
	function automatic logic exp_supported(input logic [4:0] p);
		exp_supported = (p >= `AVMF_EXP_MIN) && (p <= `AVMF_EXP_MAX);
	endfunction

endpackage

//--- hw/avmf_mask_bank.sv
/*
 * Alert mask bank: the fixed miscellaneous mask, the writable vendor
 * mask and the masked alert request.
 * Assumes the parent decodes the command and pulses wr_en for a valid
 * vendor-mask word write.
 */
`timescale 1ns/1ps
`include "avmf_regs.svh"

module avmf_mask_bank (
	input  wire logic       clk,           // System clock
	input  wire logic       resetn,        // Synchronous reset, active low
	input  wire logic       ce,            // Clock enable
	input  wire logic       wr_en,         // Vendor mask write pulse
	input  wire logic [7:0] wr_mask,       // Vendor mask write data
	input  wire logic       nvm_load,      // Reload from nonvolatile copy
	input  wire logic [7:0] nvm_mask,      // Nonvolatile vendor mask
	input  wire logic [7:0] misc_status,   // Misc status group
	input  wire logic [7:0] vendor_status, // Vendor status group
	output logic      [7:0] misc_mask,     // Misc mask readback
	output logic      [7:0] vendor_mask,   // Vendor mask readback
	output logic            alert_req      // Any unmasked supported condition
);

	avmf_pkg::avmf_bank_state_t st_reg;
	avmf_pkg::avmf_bank_state_t st_next;

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb
	begin
		st_next = st_reg;
		// Reload wins over a host write in the same cycle
		if (nvm_load)
			st_next.vendor_mask = nvm_mask & `AVMF_VENDOR_WMASK;
		else if (wr_en)
			st_next.vendor_mask = wr_mask & `AVMF_VENDOR_WMASK;
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
			st_reg <= '{vendor_mask: `AVMF_VENDOR_MASK_RST};
		else if (ce)
			st_reg <= st_next;
	end

	// ************************************************************
	// Readback and alert request
	// ************************************************************
	assign misc_mask   = `AVMF_MISC_MASK_RST;
	assign vendor_mask = st_reg.vendor_mask;

	// A cleared self-check or sync bit passes power-up and stack-enable
	// glitches straight to the line; software must expect them.
	assign alert_req = |(vendor_status & ~st_reg.vendor_mask
			& `AVMF_VENDOR_WMASK)
		| |(misc_status & ~misc_mask & `AVMF_MISC_SUPPORTED);

endmodule

//--- hw/avmf_scaler.sv
/*
 * Re-scales one output-voltage word from an old exponent to a new one.
 * Assumes exponents are within -12..-4, so the shift is at most eight.
 */
`timescale 1ns/1ps

module avmf_scaler (
	input  wire logic [15:0] value,      // Word in the old format
	input  wire logic [4:0]  old_exp,    // Exponent it was written with
	input  wire logic [4:0]  new_exp,    // Exponent now in force
	input  wire logic        signed_fmt, // Treat word as two's complement
	output logic      [15:0] result      // Word in the new format
);

	logic [5:0] diff;
	logic [5:0] neg_diff;
	logic [3:0] amt;

	// Finer new exponent means a larger mantissa for the same voltage.
	// Left shifts are not saturated: bits above 15 are lost.
	always_comb
	begin
		diff     = {old_exp[4], old_exp} - {new_exp[4], new_exp};
		neg_diff = 6'h00 - diff;
		if (!diff[5])
		begin
			amt    = diff[3:0];
			result = value << amt;
		end
		else
		begin
			amt = neg_diff[3:0];
			if (signed_fmt)
				result = 16'($signed(value) >>> amt);
			else
				result = value >> amt;
		end
	end

endmodule

//--- tb/avmf_host.sv
/*
 * Host model: issues one decoded bus command and returns the answer.
 * Assumes the block answers on the taking edge, half a cycle before the read.
 */
`timescale 1ns/1ps

module avmf_host (
	input  wire logic                clk, // System clock
	input  wire avmf_pkg::avmf_rsp_t rsp, // Answer from the block
	output avmf_pkg::avmf_cmd_t      cmd  // Request to the block
);
	// ****************
	// Command issue
	// ****************
	initial
		cmd = '0;

	// Valid is a one-cycle pulse; the answer is read a full cycle later
	task automatic xfer(input avmf_pkg::avmf_xfer_t k,
		input logic [7:0] c, s, d, output avmf_pkg::avmf_rsp_t r);
		@(negedge clk);
		cmd <= '{1'b1, k, c, s, d};
		@(negedge clk);
		cmd.valid <= 1'b0;
		r = rsp;
	endtask
endmodule

//--- tb/avmf_block_assertions.sv
/*
 * Concurrent checks on the ports of the format/mask block.
 * Assumes one clock domain and a synchronous active-low reset.
 */
`timescale 1ns/1ps
`include "avmf_regs.svh"

module avmf_block_checker (
	input wire logic                clk,           // Clock
	input wire logic                resetn,        // Reset, low
	input wire logic                ce,            // Clock enable
	input wire avmf_pkg::avmf_cmd_t cmd,           // Command
	input wire avmf_pkg::avmf_rsp_t rsp,           // Answer
	input wire avmf_pkg::avmf_nvm_t nvm,           // NVM reload
	input wire logic                conv_enabled,  // Converter on
	input wire logic [7:0]          misc_status,   // Misc status
	input wire logic [7:0]          vendor_status, // Vendor status
	input wire logic                alert_in,      // Alert wire
	input wire logic                alert_out,     // Alert level
	input wire logic                alert_oe_n,    // Alert drive
	input wire logic [7:0]          vout_format,   // Format
	input wire logic                conv_busy,     // Re-scale busy
	input wire logic [1:0]          dep_addr,      // Word index
	input wire logic                dep_rd,        // Word read
	input wire logic [15:0]         dep_rdata,     // Word in
	input wire logic                dep_wr,        // Word write
	input wire logic [15:0]         dep_wdata      // Word out
);
	// ****************
	// Decode helpers
	// ****************
	logic take;
	logic fmt_wb;
	logic mask_pc;
	logic exp_ok;
	assign take    = cmd.valid && ce;
	assign fmt_wb  = take && cmd.kind == avmf_pkg::AVMF_XFER_WRITE_BYTE
		&& cmd.code == `AVMF_CMD_VOUT_FORMAT;
	assign mask_pc = take && cmd.kind == avmf_pkg::AVMF_XFER_PROC_CALL
		&& cmd.code == `AVMF_CMD_ALERT_MASK;
	assign exp_ok  = cmd.data[4:0] >= `AVMF_EXP_MIN
		&& cmd.data[4:0] <= `AVMF_EXP_MAX;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	// ****************
	// Properties
	// ****************
	a_rsp_follows: assert property (take |=> rsp.valid)
		else $error("command not answered next cycle");
	a_no_stray_rsp: assert property (ce && !cmd.valid |=> !rsp.valid)
		else $error("answer without a command");
	a_nack_no_data: assert property (rsp.valid && !rsp.ack |->
		rsp.data == 8'h00) else $error("refused answer carries data");
	a_misc_fixed: assert property (mask_pc && cmd.sel == `AVMF_SEL_MISC
		|=> rsp.ack && rsp.data == `AVMF_MISC_MASK_RST)
		else $error("misc mask not read as fixed value");
	a_fmt_locked: assert property (fmt_wb && conv_enabled && !nvm.load
		|=> !rsp.ack && $stable(vout_format))
		else $error("format changed while converter running");
	a_mode_fixed: assert property (vout_format[6:5] == 2'b00)
		else $error("format mode field not linear");
	a_exp_refused: assert property (fmt_wb && !exp_ok |=> !rsp.ack)
		else $error("unsupported exponent accepted");
	a_fmt_lands: assert property (fmt_wb && !nvm.load ##1 rsp.ack
		|-> vout_format == {$past(cmd.data[7]), 2'b00, $past(cmd.data[4:0])})
		else $error("accepted format byte not in force");
	a_alert_masked: assert property (ce && $past(resetn) &&
		(vendor_status & `AVMF_VENDOR_WMASK) == 8'h00 |=> alert_oe_n)
		else $error("alert driven without an unmasked source");
	a_alert_od: assert property (alert_out == 1'b0)
		else $error("alert line driven high");
	a_walk_pair: assert property (dep_rd && ce && !nvm.load
		|=> dep_wr && $stable(dep_addr))
		else $error("word read not followed by its write");
endmodule

bind avmf_block avmf_block_checker u_avmf_block_checker (
	.clk(clk), .resetn(resetn), .ce(ce), .cmd(cmd), .rsp(rsp), .nvm(nvm),
	.conv_enabled(conv_enabled), .misc_status(misc_status),
	.vendor_status(vendor_status), .alert_in(alert_in),
	.alert_out(alert_out), .alert_oe_n(alert_oe_n),
	.vout_format(vout_format), .conv_busy(conv_busy), .dep_addr(dep_addr),
	.dep_rd(dep_rd), .dep_rdata(dep_rdata), .dep_wr(dep_wr),
	.dep_wdata(dep_wdata));

//--- tb/tb.sv
/*
 * Self-checking bench for the alert-mask and format command block.
 * Assumes the package, host model and checker are compiled first.
 */
`timescale 1ns/1ps
`include "avmf_regs.svh"

module tb;
	// ****************
	// Harness
	// ****************
	localparam avmf_pkg::avmf_xfer_t k_wb = avmf_pkg::AVMF_XFER_WRITE_BYTE;
	localparam avmf_pkg::avmf_xfer_t k_ww = avmf_pkg::AVMF_XFER_WRITE_WORD;
	localparam avmf_pkg::avmf_xfer_t k_rb = avmf_pkg::AVMF_XFER_READ_BYTE;
	localparam avmf_pkg::avmf_xfer_t k_pc = avmf_pkg::AVMF_XFER_PROC_CALL;
	logic                clk, resetn, ce, conv_enabled, alert_in;
	logic                alert_out, alert_oe_n, conv_busy, dep_rd, dep_wr;
	logic [7:0]          misc_status, vendor_status, vout_format, m, f, cur;
	logic [1:0]          dep_addr;
	logic [15:0]         dep_rdata, dep_wdata;
	logic [15:0]         mem [4];
	logic [15:0]         want [4];
	avmf_pkg::avmf_cmd_t cmd;
	avmf_pkg::avmf_rsp_t rsp, r;
	avmf_pkg::avmf_nvm_t nvm;
	integer              n_errors, n_checks, seed, i, j;

	avmf_block u_avmf_block (.clk(clk), .resetn(resetn), .ce(ce), .cmd(cmd),
		.rsp(rsp), .nvm(nvm), .conv_enabled(conv_enabled),
		.misc_status(misc_status), .vendor_status(vendor_status),
		.alert_in(alert_in), .alert_out(alert_out), .alert_oe_n(alert_oe_n),
		.vout_format(vout_format), .conv_busy(conv_busy),
		.dep_addr(dep_addr), .dep_rd(dep_rd), .dep_rdata(dep_rdata),
		.dep_wr(dep_wr), .dep_wdata(dep_wdata));
	avmf_host u_avmf_host (.clk(clk), .rsp(rsp), .cmd(cmd));

	// Pulled-up line; the word store shows garbage when not read
	assign alert_in  = alert_oe_n ? 1'b1 : alert_out;
	assign dep_rdata = dep_rd ? mem[dep_addr] : ~mem[dep_addr];
	always @(posedge clk)
		if (dep_wr)
			mem[dep_addr] <= dep_wdata;

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ****************
	// Tasks
	// ****************
	function automatic logic [15:0] scale(input logic [15:0] w,
		input logic [4:0] o, n, input logic sg);
		integer d;
		d = $signed(o) - $signed(n);
		if (d >= 0)
			scale = w << d;
		else if (sg)
			scale = $unsigned($signed(w) >>> -d);
		else
			scale = w >> -d;
	endfunction

	task automatic chk(input string what, input logic [15:0] seen, exp);
		n_checks = n_checks + 1;
		if (seen !== exp)
		begin
			n_errors = n_errors + 1;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic print_verdict;
		if (n_errors == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic op(input avmf_pkg::avmf_xfer_t k,
		input logic [7:0] c, s, d, a, rd);
		u_avmf_host.xfer(k, c, s, d, r);
		chk("answer valid", r.valid, 1'b1);
		chk("acknowledge", r.ack, a);
		chk("read byte", r.data, rd);
	endtask

	// ****************
	// Scenarios
	// ****************
	initial
	begin
		#50000;
		n_errors = n_errors + 1;
		print_verdict();
	end

	initial
	begin
		seed = 3;
		n_errors = 0;
		n_checks = 0;
		resetn = 1'b0;
		ce = 1'b1;
		conv_enabled = 1'b0;
		misc_status = '0;
		vendor_status = '0;
		nvm = '0;
		for (i = 0; i < 4; i++)
			mem[i] = 16'($random(seed));
		repeat (16) @(negedge clk);
		resetn = 1'b1;
		cur = `AVMF_FMT_RST;
		chk("format reset", vout_format, cur);
		chk("alert idle", alert_in, 1'b1);
		op(k_pc, 8'h1B, 8'h7F, 8'h00, 1, 8'h01);
		op(k_pc, 8'h1B, 8'h80, 8'h00, 1, `AVMF_VENDOR_MASK_RST);
		op(k_ww, 8'h1B, 8'h7F, 8'hFE, 1, 0);
		op(k_pc, 8'h1B, 8'h7F, 8'h00, 1, 8'h01);
		for (j = 0; j < 6; j++)
		begin
			m = (j == 5) ? 8'h00 : 8'($random(seed));
			op(k_ww, 8'h1B, 8'h80, m, 1, 0);
			op(k_pc, 8'h1B, 8'h80, 0, 1, m & `AVMF_VENDOR_WMASK);
		end
		for (i = 0; i < 16; i++)
		begin
			if (i == 8)
				op(k_ww, 8'h1B, 8'h80, 8'h4A, 1, 0);
			m = (i < 8) ? 8'h00 : 8'h4A;
			vendor_status = 8'h01 << (i % 8);
			misc_status = 8'($random(seed));
			repeat (2) @(negedge clk);
			chk("alert", alert_in, ~|(vendor_status & ~m & 8'hCE));
		end
		vendor_status = '0;
		conv_enabled = 1'b1;
		op(k_wb, 8'h20, 0, 8'h1A, 0, 0);
		conv_enabled = 1'b0;
		op(k_wb, 8'h20, 0, 8'h34, 0, 0);
		op(k_wb, 8'h20, 0, 8'h13, 0, 0);
		op(k_wb, 8'h20, 0, 8'h1D, 0, 0);
		op(k_ww, 8'h1B, 8'h7E, 8'h00, 0, 0);
		op(k_rb, 8'h1B, 8'h7F, 8'h00, 0, 0);
		op(k_pc, 8'h20, 0, 0, 0, 0);
		op(k_ww, 8'h21, 0, 0, 0, 0);
		op(k_rb, 8'h20, 0, 0, 1, cur);
		// Let the last answer pulse end, or the freeze would hold it
		@(negedge clk);
		ce = 1'b0;
		u_avmf_host.xfer(k_ww, 8'h1B, 8'h80, 8'hFF, r);
		chk("frozen answer", r.valid, 1'b0);
		ce = 1'b1;
		op(k_pc, 8'h1B, 8'h80, 0, 1, 8'h4A);
		for (i = 0; i < 8; i++)
		begin
			f = {1'($random(seed)), 2'b00,
				5'h14 + 5'($unsigned($random(seed)) % 9)};
			// A known change at i == 2 keeps the walk busy for the
			// write that must be refused right after it
			if (i < 3)
				f = (i == 0) ? 8'h9C : (i == 1) ? 8'h14 : 8'h18;
			for (j = 0; j < 4; j++)
				want[j] = scale(mem[j], cur[4:0], f[4:0], f[7]);
			op(k_wb, 8'h20, 0, f, 1, 0);
			if (i == 2)
				op(k_wb, 8'h20, 0, 8'h14, 0, 0);
			for (j = 0; j < 20 && conv_busy; j++)
				@(negedge clk);
			chk("format", vout_format, f);
			for (j = 0; j < 4; j++)
				chk("voltage word", mem[j], want[j]);
			cur = f;
		end
		m = 8'($random(seed));
		nvm = '{1'b1, m, 8'h98};
		@(negedge clk);
		nvm.load = 1'b0;
		chk("loaded format", vout_format, 8'h98);
		op(k_pc, 8'h1B, 8'h80, 0, 1, m & `AVMF_VENDOR_WMASK);
		print_verdict();
	end
endmodule
